// ---- fgs_stop_config.sv ----
`timescale 1ns/100ps
module fgs_stop_config #(
	parameter int unsigned CYC_PER_MS_P = fgs_pkg::CYC_PER_MS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic motor_driven,
	input wire logic stop_request,
	input wire logic brake_request,
	input wire logic align_or_open_loop,
	input wire fgs_pkg::fgs_supply_t supply_voltage_setting,
	input wire logic [15:0] phase_node_mv,
	input wire logic [13:0] motor_speed,
	input wire logic elec_tick,
	output logic speed_pulse_output,
	output logic surge_guard_enable,
	output logic deadtime_comp_enable,
	output logic bridge_hiz,
	output logic recirc_active,
	output logic low_side_brake,
	output logic spin_down_active,
	output logic [7:0] phase_resistance,
	output logic [7:0] phase_inductance,
	output logic stop_done
);
	import fgs_pkg::*;

	// ==========================================
	// registers
	logic [31:0] cl1_reg;
	logic [31:0] cl2_reg;
	logic [31:0] maxspd_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	fgs_state_t state_reg;
	fgs_state_t state_next;
	logic [16:0] sub_reg;
	logic [16:0] sub_next;
	logic [13:0] ms_reg;
	logic [13:0] ms_next;

	// ==========================================
	// apb decode
	wire logic hit_cl1 = paddr == ADDR_CL1;
	wire logic hit_cl2 = paddr == ADDR_CL2;
	wire logic hit_max = paddr == ADDR_MAXSPD;
	wire logic hit_sts = paddr == ADDR_STATUS;
	wire logic hit_any = hit_cl1 | hit_cl2 | hit_max | hit_sts;
	wire logic access_w = psel & penable;
	wire logic wr_w = access_w & pwrite & hit_any;
	wire logic setup_w = psel & ~penable;
	wire logic [31:0] status_w;
	wire logic [31:0] rd_mux_w;

	assign pready = 1'b1;
	assign pslverr = access_w & ~hit_any;
	assign prdata = prdata_reg;

	// ==========================================
	// field views
	wire logic [3:0] div_f = cl1_reg[DIV_LSB +: 4];
	wire logic gate_f = cl1_reg[GATE_BIT];
	wire logic [2:0] thr_f = cl1_reg[THR_LSB +: 3];
	wire logic slow_brk_f = cl1_reg[SLOW_BRK_BIT];
	wire logic [2:0] stop_f = cl2_reg[STOP_LSB +: 3];
	wire logic [3:0] brkt_f = cl2_reg[BRKT_LSB +: 4];
	wire logic [3:0] spin_f = cl2_reg[SPIN_LSB +: 4];
	wire logic [3:0] brkspd_f = cl2_reg[BRKSPD_LSB +: 4];
	wire logic [13:0] max_speed_f = maxspd_reg[13:0];

	// ==========================================
	// back-emf threshold compare
	logic [4:0] thr_mv_w;
	logic [4:0] gain_w;
	wire logic [15:0] thr_scaled_w;
	wire logic bemf_above_w;
	wire logic pulse_en_w;

	always_comb begin
		case (thr_f)
			3'h0: thr_mv_w = 5'h01;
			3'h1: thr_mv_w = 5'h02;
			3'h2: thr_mv_w = 5'h05;
			3'h3: thr_mv_w = 5'h0a;
			3'h4: thr_mv_w = 5'h14;
			default: thr_mv_w = 5'h1e;
		endcase
	end

	always_comb begin
		case (supply_voltage_setting)
			SUP_15: gain_w = 5'h05;
			SUP_30: gain_w = 5'h0a;
			default: gain_w = 5'h14;
		endcase
	end

	// phase node over gain against threshold, done as a product
	assign thr_scaled_w = 16'(thr_mv_w) * 16'(gain_w);
	assign bemf_above_w = phase_node_mv >= thr_scaled_w;
	assign pulse_en_w = motor_driven & (~gate_f | bemf_above_w);

	fgs_pulse_div u_div (
		.clock(clock),
		.rst_n(rst_n),
		.enable(pulse_en_w),
		.elec_tick(elec_tick),
		.div_code(div_f),
		.pulse_out(speed_pulse_output)
	);

	// ==========================================
	// speed thresholds
	wire logic [24:0] speed_x_w = 25'(motor_speed) * 25'(PCT_FULL);
	wire logic [24:0] brk_lim_w = 25'(max_speed_f) * 25'(pct_tenths(brkspd_f));
	wire logic [24:0] spin_lim_w = 25'(max_speed_f) * 25'(pct_tenths(spin_f));
	wire logic below_brk_w = speed_x_w < brk_lim_w;
	wire logic below_spin_w = speed_x_w < spin_lim_w;
	wire fgs_stop_t method_w = stop_decode(stop_f);
	wire logic any_req_w = stop_request | brake_request;

	// ==========================================
	// brake timer
	wire logic ms_tick_w = sub_reg == 17'(CYC_PER_MS_P - 1);
	wire logic brake_end_w = ms_reg >= brake_ms(brkt_f);

	always_comb begin
		sub_next = 17'h00000;
		ms_next = 14'h0000;
		if (state_reg == ST_BRAKE) begin
			sub_next = ms_tick_w ? 17'h00000 : sub_reg + 17'h00001;
			ms_next = ms_tick_w ? ms_reg + 14'h0001 : ms_reg;
		end
	end

	// ==========================================
	// stop sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (stop_request) begin
					case (method_w)
						STOP_RECIRC: begin
							if (!align_or_open_loop)
								state_next = ST_RECIRC;
							else if (slow_brk_f)
								state_next = ST_WAIT_SPD;
							else
								state_next = ST_DONE;
						end
						STOP_LSBRAKE: state_next = ST_WAIT_SPD;
						STOP_SPIN: state_next = ST_SPIN;
						default: state_next = ST_DONE;
					endcase
				end else if (brake_request) begin
					state_next = ST_WAIT_SPD;
				end
			end
			ST_RECIRC: begin
				if (!stop_request)
					state_next = ST_RUN;
			end
			ST_WAIT_SPD: begin
				if (!any_req_w)
					state_next = ST_RUN;
				else if (below_brk_w)
					state_next = ST_BRAKE;
			end
			ST_BRAKE: begin
				if (!any_req_w)
					state_next = ST_RUN;
				else if (brake_end_w)
					state_next = ST_DONE;
			end
			ST_SPIN: begin
				if (!stop_request)
					state_next = ST_RUN;
				else if (below_spin_w)
					state_next = ST_DONE;
			end
			ST_DONE: begin
				if (!any_req_w)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	// ==========================================
	// outputs
	assign surge_guard_enable = cl1_reg[SURGE_BIT];
	assign deadtime_comp_enable = cl1_reg[DTC_BIT];
	assign phase_resistance = cl2_reg[RES_LSB +: 8];
	assign phase_inductance = cl2_reg[IND_LSB +: 8];
	assign bridge_hiz = (state_reg == ST_DONE) | (state_reg == ST_WAIT_SPD);
	assign recirc_active = state_reg == ST_RECIRC;
	assign low_side_brake = state_reg == ST_BRAKE;
	assign spin_down_active = state_reg == ST_SPIN;
	assign stop_done = state_reg == ST_DONE;

	// ==========================================
	// read path, captured in the setup phase
	assign status_w = {24'h000000, bemf_above_w, pulse_en_w,
		below_brk_w, below_spin_w, 1'b0, state_reg};
	assign rd_mux_w = hit_cl1 ? (cl1_reg & CL1_MASK) :
		hit_cl2 ? (cl2_reg & CL2_MASK) :
		hit_max ? (maxspd_reg & MAXSPD_MASK) :
		hit_sts ? status_w : 32'h0000_0000;

	always_comb begin
		prdata_next = prdata_reg;
		if (setup_w)
			prdata_next = rd_mux_w;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cl1_reg <= CL1_RESET;
			cl2_reg <= CL2_RESET;
			maxspd_reg <= MAXSPD_RESET;
		end else if (wr_w) begin
			if (hit_cl1)
				cl1_reg <= pwdata & CL1_MASK;
			if (hit_cl2)
				cl2_reg <= pwdata & CL2_MASK;
			if (hit_max)
				maxspd_reg <= pwdata & MAXSPD_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ST_RUN;
			sub_reg <= 17'h00000;
			ms_reg <= 14'h0000;
			prdata_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			sub_reg <= sub_next;
			ms_reg <= ms_next;
			prdata_reg <= prdata_next;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_PULSE_GATE: assert property (
		!pulse_en_w |=> !speed_pulse_output)
		else $error("speed pulse active while gated off");

	AST_THR_NA: assert property (
		(thr_f == 3'h6 || thr_f == 3'h7) |-> thr_mv_w == 5'h1e)
		else $error("unused threshold code not held at 30 mV");

	AST_GAIN60: assert property (
		(supply_voltage_setting == SUP_60 && thr_f == 3'h0)
		|-> thr_scaled_w == 16'h0014)
		else $error("gain for supply 60 not 20");

	AST_SURGE: assert property (
		(wr_w && hit_cl1) |=> surge_guard_enable == $past(pwdata[3]))
		else $error("surge guard enable does not follow write");

	AST_DTC: assert property (
		(wr_w && hit_cl1 && !pwdata[2]) ##1 !(wr_w && hit_cl1)
		|-> !deadtime_comp_enable)
		else $error("deadtime compensation on after clear");

	AST_SLOW_HIZ: assert property (
		(state_reg == ST_RUN && stop_request && stop_f == 3'h1 &&
		align_or_open_loop && !slow_brk_f) |=> bridge_hiz && !low_side_brake)
		else $error("slow recirculation stop not hi-z");

	AST_UNDEF: assert property (
		(state_reg == ST_RUN && stop_request && stop_f >= 3'h5)
		|=> stop_done)
		else $error("undefined stop code not hi-z");

	AST_BRAKE_SPD: assert property (
		(state_reg == ST_WAIT_SPD && !below_brk_w) |=> !low_side_brake)
		else $error("brake applied above speed threshold");

	AST_BRAKE_1MS: assert property (
		($rose(low_side_brake) && brkt_f == 4'h0) |->
		low_side_brake [*2])
		else $error("brake released too early");

	AST_RSV31: assert property (
		(setup_w && hit_cl2) |=> !prdata[31])
		else $error("reserved bit 31 reads one");

endmodule

// ---- fgs_pkg.sv ----
// Behaviour
// - speed pulse divider: codes 0 and 1 divide by one, others by code
// - gating 0 keeps pulse while driven; 1 stops pulse below back-emf threshold
// - back-emf threshold codes 0..5 give 1,2,5,10,20,30 mV; 6,7 not applicable (the code holds codes 6,7 at 30 mV)
// - threshold gain 20, 10, 5 V/V for supply settings 60, 30, 15
// - anti voltage surge active only while enable bit 3 is one
// - deadtime compensation applied only while enable bit 2 is one
// - recirculation stop in align or open loop: bit 0 picks hi-z or brake
// - stop method: 0 hi-z, 1 recirculation, 2-3 low side brake, 4 spin down
// - brake time codes: 0-4 give 1 ms, then 5 up to 15000 ms
// - spin down speed threshold in percent steps of maximum speed
// - braking applied only below the brake speed threshold, pin or stop option
// - phase resistance in bits 15-8, phase inductance in bits 7-0
// - stop register at index 8a, resets to zero, bit 31 reads zero
// - maximum speed is a 14-bit field in electrical hertz
package fgs_pkg;

	// ==========================================
	// register map
	localparam logic [9:0] IDX_CL1 = 10'h088;
	localparam logic [9:0] IDX_CL2 = 10'h08a;
	localparam logic [9:0] IDX_MAXSPD = 10'h08e;
	localparam logic [9:0] IDX_STATUS = 10'h090;
	localparam logic [11:0] ADDR_CL1 = {IDX_CL1, 2'b00};
	localparam logic [11:0] ADDR_CL2 = {IDX_CL2, 2'b00};
	localparam logic [11:0] ADDR_MAXSPD = {IDX_MAXSPD, 2'b00};
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [31:0] CL1_RESET = 32'h0000_0000;
	localparam logic [31:0] CL2_RESET = 32'h0000_0000;
	localparam logic [31:0] MAXSPD_RESET = 32'h0000_0000;
	localparam logic [31:0] CL1_MASK = 32'h0000_0ffd;
	localparam logic [31:0] CL2_MASK = 32'h7fff_ffff;
	localparam logic [31:0] MAXSPD_MASK = 32'h0000_3fff;

	// ==========================================
	// field positions
	localparam int DIV_LSB = 8;
	localparam int GATE_BIT = 7;
	localparam int THR_LSB = 4;
	localparam int SURGE_BIT = 3;
	localparam int DTC_BIT = 2;
	localparam int SLOW_BRK_BIT = 0;
	localparam int STOP_LSB = 28;
	localparam int BRKT_LSB = 24;
	localparam int SPIN_LSB = 20;
	localparam int BRKSPD_LSB = 16;
	localparam int RES_LSB = 8;
	localparam int IND_LSB = 0;

	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] PCT_FULL = 11'h3e8;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		SUP_15 = 2'b00,
		SUP_30 = 2'b01,
		SUP_60 = 2'b10
	} fgs_supply_t;

	typedef enum logic [2:0] {
		STOP_HIZ = 3'b000,
		STOP_RECIRC = 3'b001,
		STOP_LSBRAKE = 3'b010,
		STOP_SPIN = 3'b100
	} fgs_stop_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_RECIRC = 3'b001,
		ST_WAIT_SPD = 3'b010,
		ST_BRAKE = 3'b011,
		ST_SPIN = 3'b100,
		ST_DONE = 3'b101
	} fgs_state_t;

	// ==========================================
	// decoders
	function automatic fgs_stop_t stop_decode(input logic [2:0] code);
		case (code)
			3'h1: stop_decode = STOP_RECIRC;
			3'h2, 3'h3: stop_decode = STOP_LSBRAKE;
			3'h4: stop_decode = STOP_SPIN;
			default: stop_decode = STOP_HIZ;
		endcase
	endfunction

	function automatic logic [13:0] brake_ms(input logic [3:0] code);
		case (code)
			4'h5: brake_ms = 14'h0005;
			4'h6: brake_ms = 14'h000a;
			4'h7: brake_ms = 14'h0032;
			4'h8: brake_ms = 14'h0064;
			4'h9: brake_ms = 14'h00fa;
			4'ha: brake_ms = 14'h01f4;
			4'hb: brake_ms = 14'h03e8;
			4'hc: brake_ms = 14'h09c4;
			4'hd: brake_ms = 14'h1388;
			4'he: brake_ms = 14'h2710;
			4'hf: brake_ms = 14'h3a98;
			default: brake_ms = 14'h0001;
		endcase
	endfunction

	// percent of maximum speed in tenths
	function automatic logic [10:0] pct_tenths(input logic [3:0] code);
		case (code)
			4'h0: pct_tenths = 11'h3e8;
			4'h1: pct_tenths = 11'h384;
			4'h2: pct_tenths = 11'h320;
			4'h3: pct_tenths = 11'h2bc;
			4'h4: pct_tenths = 11'h258;
			4'h5: pct_tenths = 11'h1f4;
			4'h6: pct_tenths = 11'h1c2;
			4'h7: pct_tenths = 11'h190;
			4'h8: pct_tenths = 11'h15e;
			4'h9: pct_tenths = 11'h12c;
			4'ha: pct_tenths = 11'h0fa;
			4'hb: pct_tenths = 11'h0c8;
			4'hc: pct_tenths = 11'h096;
			4'hd: pct_tenths = 11'h064;
			4'he: pct_tenths = 11'h032;
			default: pct_tenths = 11'h019;
		endcase
	endfunction

endpackage

// ---- fgs_pulse_div.sv ----
`timescale 1ns/100ps
module fgs_pulse_div (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic elec_tick,
	input wire logic [3:0] div_code,
	output logic pulse_out
);
	import fgs_pkg::*;

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic pulse_reg;
	logic pulse_next;
	wire logic [3:0] last_w;
	wire logic wrap_w;

	// ==========================================
	// divide by code, codes 0 and 1 divide by one
	assign last_w = (div_code < 4'h2) ? 4'h0 : div_code - 4'h1;
	assign wrap_w = cnt_reg >= last_w;

	always_comb begin
		cnt_next = cnt_reg;
		pulse_next = pulse_reg;
		if (!enable) begin
			cnt_next = 4'h0;
			pulse_next = 1'b0;
		end else if (elec_tick) begin
			cnt_next = wrap_w ? 4'h0 : cnt_reg + 4'h1;
			pulse_next = wrap_w ? ~pulse_reg : pulse_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_reg <= 4'h0;
			pulse_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			pulse_reg <= pulse_next;
		end
	end

	assign pulse_out = pulse_reg;

endmodule

// ---- fgs_motor_model.sv ----
`timescale 1ns/100ps
module fgs_motor_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick_en,
	input wire logic driven,
	input wire logic [13:0] spd_set,
	input wire logic [15:0] bemf_mv,
	input wire logic low_side_brake,
	input wire logic spin_down_active,
	output logic elec_tick,
	output logic [15:0] phase_node_mv,
	output logic [13:0] motor_speed
);
	logic [1:0] ph_reg;
	// ==========================================
	// rotor: holds commanded speed while driven, slows while braked
	always_ff @(posedge clock) begin
		if (!rst_n || driven) begin
			motor_speed <= spd_set;
		end else if ((low_side_brake || spin_down_active) &&
			motor_speed > 14'h8) begin
			motor_speed <= motor_speed - 14'h0008;
		end
		if (!rst_n) begin
			ph_reg <= 2'h0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
		end
	end
	// one electrical event every fourth cycle
	assign elec_tick = tick_en && ph_reg == 2'h3;
	assign phase_node_mv = bemf_mv;
endmodule

// ---- fgs_stop_config_test.sv ----
`timescale 1ns/100ps
module fgs_stop_config_test;
	import fgs_pkg::*;
	localparam int CPM = 10;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, tick_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic motor_driven, stop_request, brake_request, align_or_open_loop;
	fgs_supply_t supply_voltage_setting;
	logic [15:0] phase_node_mv, bemf_mv;
	logic [13:0] motor_speed, spd_set;
	logic elec_tick, speed_pulse_output, surge_guard_enable;
	logic deadtime_comp_enable, bridge_hiz, recirc_active, low_side_brake;
	logic spin_down_active, stop_done;
	logic [7:0] phase_resistance, phase_inductance;
	logic [32:0] exp_q[$];
	int err_count, n_tests, cyc, n, t, tg, brk, rec, spn, m;
	int codes[6] = '{0, 1, 2, 3, 7, 15};

	fgs_stop_config #(.CYC_PER_MS_P(CPM)) fgs_stop_config_inst (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .motor_driven(motor_driven),
		.stop_request(stop_request), .brake_request(brake_request),
		.align_or_open_loop(align_or_open_loop),
		.supply_voltage_setting(supply_voltage_setting),
		.phase_node_mv(phase_node_mv), .motor_speed(motor_speed),
		.elec_tick(elec_tick), .speed_pulse_output(speed_pulse_output),
		.surge_guard_enable(surge_guard_enable),
		.deadtime_comp_enable(deadtime_comp_enable), .bridge_hiz(bridge_hiz),
		.recirc_active(recirc_active), .low_side_brake(low_side_brake),
		.spin_down_active(spin_down_active),
		.phase_resistance(phase_resistance),
		.phase_inductance(phase_inductance), .stop_done(stop_done));

	fgs_motor_model fgs_motor_model_inst (
		.clock(clock), .rst_n(rst_n), .tick_en(tick_en),
		.driven(motor_driven), .spd_set(spd_set), .bemf_mv(bemf_mv),
		.low_side_brake(low_side_brake), .spin_down_active(spin_down_active),
		.elec_tick(elec_tick), .phase_node_mv(phase_node_mv),
		.motor_speed(motor_speed));

	// ==========================================
	// common checks and bus cycles
	task automatic chk(input logic [32:0] got, input logic [32:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		exp_q.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask

	// ticks handed over, toggles of the divided pulse counted
	task automatic pulses(input int nt, output int tg);
		int k;
		logic p;
		k = 0;
		tg = 0;
		p = speed_pulse_output;
		tick_en <= 1'b1;
		while (k < nt) begin
			@(posedge clock);
			k += (elec_tick === 1'b1);
			tg += (speed_pulse_output !== p);
			p = speed_pulse_output;
		end
		tick_en <= 1'b0;
		repeat (3) begin
			@(posedge clock);
			tg += (speed_pulse_output !== p);
			p = speed_pulse_output;
		end
	endtask

	task automatic end_sim;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================
	// read watcher
	always @(posedge clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				chk(33'h0, 33'h1, "unexpected read");
			end else begin
				chk({pslverr, prdata}, exp_q.pop_front(), "read");
			end
		end
	end

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		{rst_n, psel, penable, pwrite, tick_en} = 5'h0;
		{stop_request, brake_request, align_or_open_loop} = 3'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		motor_driven = 1'b1;
		spd_set = 14'h1f4;
		bemf_mv = 16'h0;
		supply_voltage_setting = SUP_15;
		void'($urandom(22));
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(ADDR_CL2, 33'h0);
		rd(ADDR_CL1, 33'h0);
		rd(ADDR_MAXSPD, 33'h0);
		rd(12'h004, 33'h1_0000_0000);
		r = $urandom;
		apb(1'b1, ADDR_CL2, r | 32'h8000_0000);
		rd(ADDR_CL2, {1'b0, r & 32'h7fff_ffff});
		chk(33'(phase_resistance), 33'(r[15:8]), "res");
		chk(33'(phase_inductance), 33'(r[7:0]), "ind");
		apb(1'b1, ADDR_MAXSPD, 32'hffff_ffff);
		rd(ADDR_MAXSPD, 33'h3fff);
		for (n = 0; n < 4; n++) begin
			apb(1'b1, ADDR_CL1, 32'(n << 2));
			chk(33'(surge_guard_enable), 33'(n[1]), "surge");
			chk(33'(deadtime_comp_enable), 33'(n[0]), "dtc");
		end
		// divider, gating off, no back-emf present
		foreach (codes[i]) begin
			apb(1'b1, ADDR_CL1, 32'(codes[i] << 8));
			m = (codes[i] < 2) ? 1 : codes[i];
			pulses(4 * m, tg);
			chk(33'(tg), 33'h4, "divider");
		end
		// gating on, 10 mV threshold scaled by supply gain
		apb(1'b1, ADDR_CL1, 32'h0000_00b0);
		for (n = 0; n < 6; n++) begin
			supply_voltage_setting <= fgs_supply_t'(n / 2);
			bemf_mv <= 16'(10 * (5 << (n / 2)) - 1 + n % 2);
			motor_driven <= 1'b0;
			repeat (2) @(posedge clock);
			motor_driven <= 1'b1;
			pulses(4, tg);
			chk(33'(tg), 33'(4 * (n % 2)), "gating");
		end
		// unused threshold code acts as 30 mV, gain 5 gives 150
		apb(1'b1, ADDR_CL1, 32'h0000_00e0);
		for (n = 0; n < 2; n++) begin
			supply_voltage_setting <= SUP_15;
			bemf_mv <= 16'(149 + n);
			motor_driven <= 1'b0;
			repeat (2) @(posedge clock);
			motor_driven <= 1'b1;
			pulses(4, tg);
			chk(33'(tg), 33'(4 * n), "thr na");
		end
		// stop methods, then recirculation in align with both options
		apb(1'b1, ADDR_MAXSPD, 32'h0000_03e8);
		for (n = 0; n < 10; n++) begin
			m = (n < 8) ? n : 1;
			align_or_open_loop <= (n >= 8);
			apb(1'b1, ADDR_CL1, 32'(n == 9));
			apb(1'b1, ADDR_CL2, {1'b0, 3'(m), 4'h5, 4'hf, 4'h0, 16'h0});
			motor_driven <= 1'b0;
			stop_request <= 1'b1;
			{t, brk, rec, spn} = 0;
			while (stop_done !== 1'b1 && t < 200) begin
				@(posedge clock);
				t++;
				brk += (low_side_brake === 1'b1);
				rec += (recirc_active === 1'b1);
				spn += (spin_down_active === 1'b1);
			end
			chk(33'(stop_done), 33'(!(m == 1 && n < 8)), "done");
			chk(33'(rec > 0), 33'(m == 1 && n < 8), "recirc");
			chk(33'(spn > 0), 33'(m == 4), "spin");
			if (m == 2 || m == 3 || n == 9) begin
				chk(33'(brk >= 5 * CPM && brk <= 5 * CPM + 2), 33'h1, "brk");
			end else begin
				chk(33'(brk), 33'h0, "no brake");
			end
			stop_request <= 1'b0;
			motor_driven <= 1'b1;
			repeat (2) @(posedge clock);
			chk(33'({bridge_hiz, recirc_active, low_side_brake, spin_down_active,
				stop_done}), 33'h0, "release");
		end
		// brake pin waits for the speed threshold
		apb(1'b1, ADDR_CL2, 32'h0005_0000);
		motor_driven <= 1'b0;
		brake_request <= 1'b1;
		repeat (20) @(posedge clock);
		chk(33'({bridge_hiz, low_side_brake}), 33'h2, "above thr");
		apb(1'b1, ADDR_CL2, 32'h0004_0000);
		@(posedge clock);
		chk(33'(low_side_brake), 33'h1, "below thr");
		brake_request <= 1'b0;
		repeat (4) @(posedge clock);
		// second reset in mid run clears the written registers
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(ADDR_CL2, 33'h0);
		rd(ADDR_CL1, 33'h0);
		chk(33'(phase_resistance), 33'h0, "reset res");
		end_sim();
	end
endmodule
